// >>> common/scc_regs.vh
// Purpose: Register map, field layout, reset values and constants of the
//          strain cycle configuration block.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes:   Definitions only.
//
// Behaviour
// - Recalibrate once every N cycles, N from interval
// - Route codes select driver pair A to D
// - Routes reset to their own standard pair
// - Any route combination accepted, no override
// - Half bridge: 1e6 times difference over sum
// - Single arm: 1e6 times (g-r) over 2r
// - Jitter enable starts pseudo-random cycle offset
// - Update source: every cycle, eighth, interrupt
// - Offset added to period, span 0/4/8/16
// - Single mode idles until next start trigger
// - Span resistor scaled by programmable factor
// - Bridge offset kept apart from span term
// - Compensation only in full bridge modes
// - Span gain unsigned 8.16, zero bypasses
// - Bridge offset signed 16.8 in ppm
// - Sign bit per bridge adds or subtracts
`ifndef SCC_REGS_VH
`define SCC_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCC_ADDR_CTRL    6'h00
`define SCC_ADDR_ROUTE   6'h04
`define SCC_ADDR_CYCLE   6'h08
`define SCC_ADDR_GAIN1   6'h0C
`define SCC_ADDR_GAIN2   6'h10
`define SCC_ADDR_OFFS1   6'h14
`define SCC_ADDR_OFFS2   6'h18
`define SCC_ADDR_STATUS  6'h1C
`define SCC_ADDR_RESULT1 6'h20
`define SCC_ADDR_RESULT2 6'h24
`define SCC_ADDR_START   6'h28

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SCC_CAL_LSB      0
`define SCC_JIT_EN_BIT   4
`define SCC_JIT_SRC_LSB  5
`define SCC_JIT_SPAN_LSB 7
`define SCC_SINGLE_BIT   9
`define SCC_QUARTER_BIT  10
`define SCC_BMODE_LSB    11
`define SCC_RUN_BIT      13
`define SCC_SIGN1_BIT    14
`define SCC_SIGN2_BIT    15

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SCC_CTRL_RST     16'h0000
`define SCC_ROUTE_RST    8'hE4
`define SCC_CYCLE_RST    16'h0100
`define SCC_BMODE_HALF   2'h0
`define SCC_BMODE_FULL   2'h1
`define SCC_BMODE_DOUBLE 2'h2
`define SCC_PPM_SCALE    20'hF4240
`define SCC_DIV_STEPS    6'h28
`define SCC_LFSR_SEED    16'hACE1

`endif

// >>> logic/scc_lfsr.v
// Purpose: 16-bit maximal-length pseudo-random source for cycle jitter.
// Assumes: Taps 16,15,13,4 (x^16+x^15+x^13+x^4+1).
// Notes:   Advances one step per cycle in which step is high.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"

module scc_lfsr (
    input wire clk,
    input wire rst_n,
    input wire step,
    output reg [15:0] value_q
);

    wire feedback;

    assign feedback = value_q[15] ^ value_q[14] ^ value_q[12] ^ value_q[3];

    // ----------------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= `SCC_LFSR_SEED;
        end else if (step) begin
            value_q <= {value_q[14:0], feedback};
        end
    end

endmodule
`default_nettype wire

// >>> logic/scc_top.v
// Purpose: Measurement cycle, calibration, driver routing, jitter and
//          result arithmetic with span and offset compensation.
// Assumes: Gauge inputs come from logic on SYS_CLK and hold steady while
//          CYCLE_END rises; START_TRIG comes from outside the domain.
// Notes:   Reads take one wait state, writes none; response always OKAY.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"

module scc_top (
    input wire SYS_CLK,
    input wire NRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire START_TRIG,
    input wire [3:0] DRIVE_REQ,
    input wire [15:0] GAUGE_A,
    input wire [15:0] GAUGE_B,
    input wire [15:0] SPAN_RES,
    output reg [3:0] PAIR_DRIVE,
    output reg CAL_REQ,
    output reg CYCLE_END,
    output reg RESULT_VALID,
    output reg BRIDGE_INDEX
);

    localparam ST_IDLE = 2'h0;
    localparam ST_COUNT = 2'h1;
    localparam ST_CALC = 2'h2;
    localparam ST_STORE = 2'h3;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [15:0] ctrl_q, cycle_q;
    reg [7:0] route_q;
    reg [23:0] gain1_q, gain2_q, offs1_q, offs2_q;
    reg [31:0] result1_q, result2_q;
    reg wr_pend_q, rd_pend_q;
    reg [5:0] addr_q;
    reg sw_start_q;
    reg trig_s1_q, trig_s2_q, trig_s3_q;
    reg [1:0] state_q;
    reg [16:0] cnt_q;
    reg [3:0] cal_cnt_q;
    reg [2:0] eighth_q;
    reg [39:0] num_q, quo_q;
    reg [17:0] den_q;
    reg [18:0] rem_q;
    reg neg_q;
    reg [5:0] step_q;
    reg [15:0] span_res_q;

    wire [15:0] lfsr_q;
    wire [3:0] cal_ival;
    wire [1:0] jit_src, jit_span, bmode;
    wire ap_valid, jit_en, single_mode, quarter, run_en, trig_rise, start_ev;

    assign cal_ival = ctrl_q[`SCC_CAL_LSB+3:`SCC_CAL_LSB];
    assign jit_en = ctrl_q[`SCC_JIT_EN_BIT];
    assign jit_src = ctrl_q[`SCC_JIT_SRC_LSB+1:`SCC_JIT_SRC_LSB];
    assign jit_span = ctrl_q[`SCC_JIT_SPAN_LSB+1:`SCC_JIT_SPAN_LSB];
    assign single_mode = ctrl_q[`SCC_SINGLE_BIT];
    assign quarter = ctrl_q[`SCC_QUARTER_BIT];
    assign bmode = ctrl_q[`SCC_BMODE_LSB+1:`SCC_BMODE_LSB];
    assign run_en = ctrl_q[`SCC_RUN_BIT];
    assign ap_valid = HSEL & HTRANS[1] & HREADY;
    assign trig_rise = trig_s2_q & ~trig_s3_q;
    assign start_ev = trig_rise | sw_start_q;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Cycles between calibrations for an interval code
    function [3:0] cal_period;
        input [3:0] code;
        begin
            if (code == 4'h0) begin
                cal_period = 4'h1;
            end else if (code == 4'hF) begin
                cal_period = 4'hF;
            end else begin
                cal_period = code + 4'h1;
            end
        end
    endfunction

    // Jitter offset masked to the selected span
    function [4:0] jitter_mask;
        input [1:0] span;
        input [15:0] rnd;
        begin
            case (span)
                2'h1: jitter_mask = {3'h0, rnd[1:0]};
                2'h2: jitter_mask = {2'h0, rnd[2:0]};
                2'h3: jitter_mask = {1'b0, rnd[3:0]};
                default: jitter_mask = 5'h00;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 6'h00;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
        end else begin
            wr_pend_q <= ap_valid & HWRITE;
            if (ap_valid) begin
                addr_q <= HADDR[5:0];
            end
            if (ap_valid & ~HWRITE) begin
                rd_pend_q <= 1'b1;
                HREADYOUT <= 1'b0;
            end else if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                HREADYOUT <= 1'b1;
                HRDATA <= read_mux(addr_q);
            end
        end
    end

    function [31:0] read_mux;
        input [5:0] a;
        begin
            case (a)
                `SCC_ADDR_CTRL: read_mux = {16'h0000, ctrl_q};
                `SCC_ADDR_ROUTE: read_mux = {24'h000000, route_q};
                `SCC_ADDR_CYCLE: read_mux = {16'h0000, cycle_q};
                `SCC_ADDR_GAIN1: read_mux = {8'h00, gain1_q};
                `SCC_ADDR_GAIN2: read_mux = {8'h00, gain2_q};
                `SCC_ADDR_OFFS1: read_mux = {8'h00, offs1_q};
                `SCC_ADDR_OFFS2: read_mux = {8'h00, offs2_q};
                `SCC_ADDR_STATUS: read_mux = {lfsr_q, 3'h0, BRIDGE_INDEX,
                                              cal_cnt_q, 2'h0, state_q,
                                              2'h0, single_mode,
                                              (state_q != ST_IDLE)};
                `SCC_ADDR_RESULT1: read_mux = result1_q;
                `SCC_ADDR_RESULT2: read_mux = result2_q;
                default: read_mux = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= `SCC_CTRL_RST;
            route_q <= `SCC_ROUTE_RST;
            cycle_q <= `SCC_CYCLE_RST;
            gain1_q <= 24'h000000;
            gain2_q <= 24'h000000;
            offs1_q <= 24'h000000;
            offs2_q <= 24'h000000;
            sw_start_q <= 1'b0;
        end else begin
            sw_start_q <= 1'b0;
            if (wr_pend_q) begin
                case (addr_q)
                    `SCC_ADDR_CTRL: ctrl_q <= HWDATA[15:0];
                    `SCC_ADDR_ROUTE: route_q <= HWDATA[7:0];
                    `SCC_ADDR_CYCLE: cycle_q <= HWDATA[15:0];
                    `SCC_ADDR_GAIN1: gain1_q <= HWDATA[23:0];
                    `SCC_ADDR_GAIN2: gain2_q <= HWDATA[23:0];
                    `SCC_ADDR_OFFS1: offs1_q <= HWDATA[23:0];
                    `SCC_ADDR_OFFS2: offs2_q <= HWDATA[23:0];
                    `SCC_ADDR_START: sw_start_q <= HWDATA[0];
                    default: sw_start_q <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Driver routing
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_pair
            always @(posedge SYS_CLK or negedge NRST) begin
                if (!NRST) begin
                    PAIR_DRIVE[p] <= 1'b0;
                end else begin
                    PAIR_DRIVE[p] <= (DRIVE_REQ[0] & (route_q[1:0] == p)) |
                                     (DRIVE_REQ[1] & (route_q[3:2] == p)) |
                                     (DRIVE_REQ[2] & (route_q[5:4] == p)) |
                                     (DRIVE_REQ[3] & (route_q[7:6] == p));
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Start trigger synchroniser
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= START_TRIG;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Jitter source
    // ----------------------------------------------------------------
    reg lfsr_step;
    always @* begin
        lfsr_step = 1'b0;
        if (jit_en) begin
            case (jit_src)
                2'h0: lfsr_step = CYCLE_END;
                2'h1: lfsr_step = CYCLE_END & (eighth_q == 3'h7);
                default: lfsr_step = RESULT_VALID;
            endcase
        end
    end

    scc_lfsr u_lfsr (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .step(lfsr_step),
        .value_q(lfsr_q)
    );

    wire [16:0] period_load;
    assign period_load = {1'b0, cycle_q} +
                         (jit_en ? {12'h000, jitter_mask(jit_span, lfsr_q)} : 17'h00000);

    // ----------------------------------------------------------------
    // Result arithmetic
    // ----------------------------------------------------------------
    wire [16:0] diff, abs_diff;
    wire [17:0] den_in;
    wire [36:0] num_in;
    wire [18:0] rem_sh;
    wire rem_ge;
    assign diff = {1'b0, GAUGE_A} - {1'b0, GAUGE_B};
    assign abs_diff = diff[16] ? (17'h00000 - diff) : diff;
    assign den_in = quarter ? {1'b0, GAUGE_B, 1'b0}
                            : ({2'h0, GAUGE_A} + {2'h0, GAUGE_B});
    assign num_in = abs_diff * `SCC_PPM_SCALE;
    assign rem_sh = {rem_q[17:0], num_q[39]};
    assign rem_ge = rem_sh >= {1'b0, den_q};
    wire [31:0] quo_signed, span_term, offs_term, comp_res;
    wire [39:0] span_prod;
    wire span_neg;

    assign quo_signed = neg_q ? (32'h00000000 - quo_q[31:0]) : quo_q[31:0];
    assign span_prod = span_res_q * (BRIDGE_INDEX ? gain2_q : gain1_q);
    assign span_term = {8'h00, span_prod[39:16]};
    assign span_neg = BRIDGE_INDEX ? ctrl_q[`SCC_SIGN2_BIT] : ctrl_q[`SCC_SIGN1_BIT];
    assign offs_term = BRIDGE_INDEX ? {{16{offs2_q[23]}}, offs2_q[23:8]}
                                    : {{16{offs1_q[23]}}, offs1_q[23:8]};
    assign comp_res = (span_neg ? (quo_signed - span_term)
                                : (quo_signed + span_term)) - offs_term;

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            cnt_q <= 17'h00000;
            cal_cnt_q <= 4'h0;
            eighth_q <= 3'h0;
            num_q <= 40'h0000000000;
            den_q <= 18'h00000;
            rem_q <= 19'h00000;
            quo_q <= 40'h0000000000;
            neg_q <= 1'b0;
            step_q <= 6'h00;
            span_res_q <= 16'h0000;
            result1_q <= 32'h00000000;
            result2_q <= 32'h00000000;
            CAL_REQ <= 1'b0;
            CYCLE_END <= 1'b0;
            RESULT_VALID <= 1'b0;
            BRIDGE_INDEX <= 1'b0;
        end else begin
            CAL_REQ <= 1'b0;
            CYCLE_END <= 1'b0;
            RESULT_VALID <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if ((single_mode & start_ev) | (~single_mode & run_en)) begin
                        cnt_q <= period_load;
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (cnt_q > 17'h00001) begin
                        cnt_q <= cnt_q - 17'h00001;
                    end else begin
                        CYCLE_END <= 1'b1;
                        eighth_q <= eighth_q + 3'h1;
                        if (cal_cnt_q + 4'h1 >= cal_period(cal_ival)) begin
                            CAL_REQ <= 1'b1;
                            cal_cnt_q <= 4'h0;
                        end else begin
                            cal_cnt_q <= cal_cnt_q + 4'h1;
                        end
                        num_q <= {3'h0, num_in};
                        den_q <= den_in;
                        neg_q <= diff[16];
                        rem_q <= 19'h00000;
                        quo_q <= 40'h0000000000;
                        step_q <= `SCC_DIV_STEPS;
                        span_res_q <= SPAN_RES;
                        state_q <= ST_CALC;
                    end
                end
                ST_CALC: begin
                    rem_q <= rem_ge ? (rem_sh - {1'b0, den_q}) : rem_sh;
                    quo_q <= {quo_q[38:0], rem_ge};
                    num_q <= {num_q[38:0], 1'b0};
                    step_q <= step_q - 6'h01;
                    if (step_q == 6'h01) begin
                        state_q <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    RESULT_VALID <= 1'b1;
                    if (den_q == 18'h00000) begin
                        result1_q <= 32'h00000000;
                    end else if (bmode == `SCC_BMODE_HALF) begin
                        result1_q <= quo_signed;
                    end else if (BRIDGE_INDEX) begin
                        result2_q <= comp_res;
                    end else begin
                        result1_q <= comp_res;
                    end
                    if (bmode == `SCC_BMODE_DOUBLE) begin
                        BRIDGE_INDEX <= ~BRIDGE_INDEX;
                    end else begin
                        BRIDGE_INDEX <= 1'b0;
                    end
                    if (single_mode | ~run_en) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= period_load;
                        state_q <= ST_COUNT;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> test/scc_checker.sv
// Purpose: Port-level checks of the strain cycle configuration block.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
`default_nettype none
module scc_checker (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [3:0] DRIVE_REQ,
    input wire logic [3:0] PAIR_DRIVE,
    input wire logic CAL_REQ,
    input wire logic CYCLE_END,
    input wire logic RESULT_VALID
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    wire logic taken = HSEL && HTRANS[1] && HREADY;
    resp_okay_a: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    read_wait_a: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    write_nowait_a: assert property (taken && HWRITE |=> HREADYOUT)
        else $error("write stalled");
    end_pulse_a: assert property (CYCLE_END |=> (!CYCLE_END) [*8])
        else $error("cycle end too close");
    cal_end_a: assert property (CAL_REQ |-> CYCLE_END)
        else $error("calibration outside cycle end");
    result_time_a: assert property (CYCLE_END |-> ##41 RESULT_VALID)
        else $error("result not on time");
    valid_pulse_a: assert property (RESULT_VALID |=> !RESULT_VALID)
        else $error("result valid too long");
    pair_idle_a: assert property ($past(DRIVE_REQ) == 4'h0 |-> PAIR_DRIVE == 4'h0)
        else $error("pair driven without request");
    pair_busy_a: assert property ($past(NRST, 2) && $past(DRIVE_REQ) != 4'h0
        |-> PAIR_DRIVE != 4'h0)
        else $error("request not routed");
endmodule
bind scc_top scc_checker chk_u (.SYS_CLK, .NRST, .HSEL, .HTRANS, .HWRITE, .HREADY,
    .HREADYOUT, .HRESP, .DRIVE_REQ, .PAIR_DRIVE, .CAL_REQ, .CYCLE_END, .RESULT_VALID);
`default_nettype wire

// >>> test/scc_trig_host.sv
// Purpose: Host-side start trigger source for single-conversion runs.
// Assumes: Delays are counted on the system clock.
// Notes:   The trigger is a four-cycle level.
`timescale 1ns/1ns
`default_nettype none
module scc_trig_host (
    input wire logic clk,
    input wire logic fire,
    input wire logic [3:0] dly,
    output logic trig
);
    initial trig = 1'b0;
    // Start spacing varies by a delay counted on the system clock
    always @(posedge clk) begin
        if (fire === 1'b1) begin
            repeat (dly) @(posedge clk);
            trig <= 1'b1;
            repeat (4) @(posedge clk);
            trig <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Purpose: Self-checking bench of the strain cycle configuration block.
// Assumes: 40 ns clock; bus signals change just after rising edges.
// Notes:   Random values come from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
module tb;
    logic SYS_CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, fire = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0] HTRANS = 2'h0;
    logic [3:0] DRIVE_REQ = 4'h0, dly = 4'h0, PAIR_DRIVE;
    logic [15:0] GAUGE_A = 16'h0, GAUGE_B = 16'h0, SPAN_RES = 16'h0;
    logic HREADYOUT, HRESP, START_TRIG, CAL_REQ, CYCLE_END, RESULT_VALID, BRIDGE_INDEX;
    int err_total = 0, checks = 0, seed = 63;
    always #20 SYS_CLK = ~SYS_CLK;
    scc_top dut_u (.SYS_CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .START_TRIG, .DRIVE_REQ, .GAUGE_A,
        .GAUGE_B, .SPAN_RES, .PAIR_DRIVE, .CAL_REQ, .CYCLE_END, .RESULT_VALID, .BRIDGE_INDEX);
    scc_trig_host host_u (.clk(SYS_CLK), .fire, .dly, .trig(START_TRIG));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        HSEL <= 1'b1;
        HADDR <= a;
        HTRANS <= 2'h2;
        HWRITE <= w;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic pulse(ref logic s);
        do @(posedge SYS_CLK); while (s !== 1'b1);
    endtask
    task automatic gap(output int g);
        pulse(CYCLE_END);
        g = 0;
        do begin
            @(posedge SYS_CLK);
            g++;
        end while (CYCLE_END !== 1'b1);
    endtask
    task automatic cal_gap(output int n);
        pulse(CAL_REQ);
        n = 0;
        do begin
            pulse(CYCLE_END);
            n++;
        end while (CAL_REQ !== 1'b1);
    endtask
    task automatic result(input logic [31:0] ctrl, exp);
        bus(1'b1, `SCC_ADDR_CTRL, ctrl);
        pulse(RESULT_VALID);
        pulse(RESULT_VALID);
        bus(1'b0, `SCC_ADDR_RESULT1, 32'h0);
        chk("result", rd, exp);
    endtask
    function automatic logic [31:0] pair_of(logic [7:0] r, logic [3:0] q);
        pair_of = 32'h0;
        for (int k = 0; k < 4; k++)
            if (q[k]) pair_of[r[2*k+:2]] = 1'b1;
    endfunction
    function automatic logic [31:0] ratio(longint n, longint d);
        ratio = (d == 0) ? 32'h0 : 32'(n * 1000000 / d);
    endfunction
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int g0, g, n;
        longint a, b, s, gn, of;
        logic [7:0] rt;
        logic [31:0] q;
        logic any, bi;
        repeat (8) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(posedge SYS_CLK);
        bus(1'b0, `SCC_ADDR_ROUTE, 32'h0);
        chk("route reset", rd, 32'hE4);
        bus(1'b0, `SCC_ADDR_CYCLE, 32'h0);
        chk("cycle reset", rd, 32'h100);
        bus(1'b1, 32'h30, 32'hFFFF);
        bus(1'b0, 32'h30, 32'h0);
        chk("unmapped", rd, 32'h0);
        rt = 8'hE4;
        for (int i = 0; i < 7; i++) begin
            if (i > 0) begin
                rt = (i == 1) ? 8'h00 : 8'($random(seed));
                bus(1'b1, `SCC_ADDR_ROUTE, {24'h0, rt});
            end
            for (int k = 0; k < 5; k++) begin
                q = (k < 4) ? 32'h1 << k : $random(seed);
                DRIVE_REQ <= q[3:0];
                repeat (2) @(posedge SYS_CLK);
                chk("pair drive", PAIR_DRIVE, pair_of(rt, q[3:0]));
            end
        end
        bus(1'b1, `SCC_ADDR_CYCLE, 32'h10);
        for (int i = 0; i < 4; i++) begin
            n = (i == 3) ? 15 : i * 7;
            bus(1'b1, `SCC_ADDR_CTRL, 32'h2000 | n);
            cal_gap(g);
            cal_gap(g);
            chk("cal interval", g, (n == 15) ? 15 : n + 1);
        end
        bus(1'b1, `SCC_ADDR_CTRL, 32'h2000);
        gap(g0);
        gap(g0);
        any = 1'b0;
        for (int sp = 0; sp < 4; sp++)
            for (int j = 0; j < 4; j++) begin
                bus(1'b1, `SCC_ADDR_CTRL, 32'h2010 | (j << 5) | (sp << 7));
                gap(g);
                for (int m = 0; m < 3; m++) begin
                    gap(g);
                    any = any | (g != g0);
                    chk("jitter span", g >= g0 && g - g0 < (sp == 0 ? 1 : 2 << sp), 1);
                end
            end
        chk("jitter seen", any, 1);
        for (int i = 0; i < 6; i++) begin
            a = 1000 + ($random(seed) & 32'h7FFF);
            b = 1000 + ($random(seed) & 32'h7FFF);
            gn = (i == 0) ? 0 : $random(seed) & 32'h1FFFF;
            of = $random(seed) & 32'hFFFF;
            s = $random(seed) & 32'hFFFF;
            GAUGE_A <= 16'(a);
            GAUGE_B <= 16'(b);
            SPAN_RES <= 16'(s);
            bus(1'b1, `SCC_ADDR_GAIN1, 32'(gn));
            bus(1'b1, `SCC_ADDR_OFFS1, 32'(of));
            q = ratio(a - b, a + b);
            result(32'h2000, q);
            result(32'h2400, ratio(a - b, 2 * b));
            result(32'h2800, 32'(q + ((s * gn) >> 16) - (of >> 8)));
            result(32'h6800, 32'(q - ((s * gn) >> 16) - (of >> 8)));
            bus(1'b1, `SCC_ADDR_GAIN2, 32'(gn >> 1));
            bus(1'b1, `SCC_ADDR_OFFS2, 32'(of >> 1));
            result(32'hB000, 32'(q + ((s * gn) >> 16) - (of >> 8)));
            bi = BRIDGE_INDEX;
            pulse(RESULT_VALID);
            chk("bridge index", BRIDGE_INDEX, !bi);
            bus(1'b0, `SCC_ADDR_RESULT2, 32'h0);
            chk("result2", rd, 32'(q - ((s * (gn >> 1)) >> 16) - ((of >> 1) >> 8)));
        end
        bus(1'b1, `SCC_ADDR_CTRL, 32'h0200);
        repeat (150) @(posedge SYS_CLK);
        for (int i = 0; i < 2; i++) begin
            dly <= 4'($random(seed));
            fire <= 1'b1;
            @(posedge SYS_CLK);
            fire <= 1'b0;
            pulse(RESULT_VALID);
            n = 0;
            repeat (200) begin
                @(posedge SYS_CLK);
                n += (CYCLE_END === 1'b1);
            end
            chk("single idle", n, 0);
        end
        bus(1'b1, `SCC_ADDR_START, 32'h1);
        pulse(RESULT_VALID);
        bus(1'b0, `SCC_ADDR_STATUS, 32'h0);
        chk("single status", rd[1:0], 2'h2);
        test_done();
    end
    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        #2000000;
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
